// >>> lsd_pkg.sv
// Shared constants, types and helpers for the segment/common display driver
package lsd_pkg;

   // ==========================================================
   // Panel geometry
   localparam int LSD_NSEG      = 36;
   localparam int LSD_NCOM      = 4;
   localparam int LSD_CLK_DIV   = 8;
   localparam int LSD_DIV_W     = $clog2(LSD_CLK_DIV);

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] LSD_OFF_CTRL     = 8'h00;
   localparam logic [7:0] LSD_OFF_SEG_LOW  = 8'h04;
   localparam logic [7:0] LSD_OFF_SEG_MID  = 8'h08;
   localparam logic [7:0] LSD_OFF_SEG_HIGH = 8'h0C;
   localparam logic [7:0] LSD_OFF_STATUS   = 8'h10;
   localparam logic [5:0] LSD_MEM_BASE_IDX = 6'h10;
   localparam logic [5:0] LSD_MEM_END_IDX  = 6'h34;
   localparam logic [7:0] LSD_SEG_RESET    = 8'h00;

   // ==========================================================
   // Control register fields
   localparam int LSD_CTRL_EN_BIT   = 0;
   localparam int LSD_CTRL_SRC_LO   = 4;
   localparam int LSD_CTRL_SRC_HI   = 5;
   localparam int LSD_CTRL_TYPE_BIT = 7;

   // ==========================================================
   // Bias source codes
   localparam logic [1:0] LSD_SRC_EXT   = 2'h0;
   localparam logic [1:0] LSD_SRC_REF   = 2'h1;
   localparam logic [1:0] LSD_SRC_REG3V = 2'h2;
   localparam logic [1:0] LSD_SRC_MAIN  = 2'h3;

   // ==========================================================
   // Drive level codes, ground up to full scale
   localparam logic [1:0] LSD_LVL_VSS = 2'h0;
   localparam logic [1:0] LSD_LVL_VC  = 2'h1;
   localparam logic [1:0] LSD_LVL_VB  = 2'h2;
   localparam logic [1:0] LSD_LVL_VA  = 2'h3;

   typedef struct packed {
      logic       wave_type;
      logic [1:0] bias_src;
      logic       enable;
   } lsd_ctrl_t;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
   } lsd_req_t;

   // Positive phase: selected com at VA, others at VC; negative mirrors it
   function automatic logic [1:0] lsd_com_level(input logic sel, input logic neg);
      if (sel) return neg ? LSD_LVL_VSS : LSD_LVL_VA;
      return neg ? LSD_LVL_VB : LSD_LVL_VC;
   endfunction

   function automatic logic [1:0] lsd_seg_level(input logic on, input logic neg);
      if (on) return neg ? LSD_LVL_VA : LSD_LVL_VSS;
      return neg ? LSD_LVL_VC : LSD_LVL_VB;
   endfunction

endpackage

// >>> lsd_pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module lsd_pin_sync
   import lsd_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic clk_en_in,
   input  wire logic pin_in,
   output logic      rise_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic agree;

   // Level only counts once the last two stages agree
   assign agree    = (s2_q == s3_q);
   assign rise_out = agree & s3_q & ~lvl_q & clk_en_in;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         lvl_q <= 1'b0;
      end else if (clk_en_in) begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) lvl_q <= s3_q;
      end
   end
endmodule // lsd_pin_sync
`default_nettype wire

// >>> lsd_frame_seq.sv
// Frame sequencer: divide-by-8 tick, com slot and polarity phase
`timescale 1ns/1ps
`default_nettype none
module lsd_frame_seq
   import lsd_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       clk_en_in,
   input  wire logic       src_rise_in,
   input  wire logic       run_in,
   input  wire logic       wave_type_in,
   output logic [1:0]      slot_out,
   output logic            neg_out
);
   localparam logic [LSD_DIV_W-1:0] DIV_LAST = LSD_DIV_W'(LSD_CLK_DIV - 1);

   logic [LSD_DIV_W-1:0] div_q;
   logic [1:0]           slot_q;
   logic                 neg_q;
   logic                 tick;
   logic                 slot_wrap;
   logic                 step_slot;
   logic                 step_phase;

   // ==========================================================
   // Display tick
   // divide by eight
   assign tick      = run_in & src_rise_in & (div_q == DIV_LAST);
   assign slot_wrap = (slot_q == 2'h3);
   // type B flips polarity per frame, type A every tick
   assign step_slot  = tick & (wave_type_in | neg_q);
   assign step_phase = tick & (wave_type_in ? slot_wrap : 1'b1);
   assign slot_out   = slot_q;
   assign neg_out    = neg_q;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q  <= '0;
         slot_q <= 2'h0;
         neg_q  <= 1'b0;
      end else if (clk_en_in) begin
         if (!run_in) begin
            div_q  <= '0;
            slot_q <= 2'h0;
            neg_q  <= 1'b0;
         end else begin
            if (src_rise_in) div_q <= div_q + 1'b1;
            if (step_slot) slot_q <= slot_q + 2'h1;
            if (step_phase) neg_q <= ~neg_q;
         end
      end
   end

   // ==========================================================
   // Checks
   logic [4:0] edge_cnt_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) edge_cnt_q <= '0;
      else if (clk_en_in & (!run_in | tick)) edge_cnt_q <= '0;
      else if (clk_en_in & src_rise_in) edge_cnt_q <= edge_cnt_q + 5'h1;
   end

   chk_tick_div_eight: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      tick |-> edge_cnt_q == 5'h07)
      else $error("display tick not after eight source edges");

   chk_type_b_phase: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (run_in && wave_type_in && $past(run_in) && $past(wave_type_in)
       && neg_q != $past(neg_q)) |-> slot_q == 2'h0)
      else $error("type B polarity changed mid frame");
endmodule // lsd_frame_seq
`default_nettype wire

// >>> lsd_driver.sv
// Segment/common waveform driver with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module lsd_driver
   import lsd_pkg::*;
#(
   parameter int NSEG = LSD_NSEG,
   parameter int NCOM = LSD_NCOM
) (
   input  wire logic                clk_in,
   input  wire logic                resetn_in,
   input  wire logic                clk_en_in,
   input  wire logic                sleep_in,
   input  wire logic                low_speed_subsystem_clock_in,
   input  wire logic                hsel_in,
   input  wire logic [31:0]         haddr_in,
   input  wire logic [1:0]          htrans_in,
   input  wire logic                hwrite_in,
   input  wire logic [2:0]          hsize_in,
   input  wire logic [31:0]         hwdata_in,
   input  wire logic                hready_in,
   output logic                     hreadyout_out,
   output logic                     hresp_out,
   output logic [31:0]              hrdata_out,
   output logic [2*NCOM-1:0]        com_level_out,
   output logic [2*NSEG-1:0]        seg_level_out,
   output logic [NSEG-1:0]          seg_drive_enable_out,
   output logic                     bias_supply_pin_sel_out,
   output logic [2:0]               bias_internal_sel_out,
   output logic                     display_active_out
);

   // ==========================================================
   // Register state
   lsd_ctrl_t        ctrl_q;
   logic [7:0]       seg_low_q;
   logic [7:0]       seg_mid_q;
   logic [7:0]       seg_high_q;
   logic [NCOM-1:0]  mem_q [NSEG];
   lsd_req_t         dph_q;
   logic             wr_pend_q;
   logic [31:0]      hrdata_q;
   logic             hreadyout_q;
   // Response kept in a flop so every bus output is registered
   logic             hresp_q;
   logic [2*NCOM-1:0] com_level_q;
   logic [2*NSEG-1:0] seg_level_q;
   logic [NSEG-1:0]  seg_en_q;
   logic             bias_ext_q;
   logic [2:0]       bias_int_q;
   logic             active_q;

   // ==========================================================
   // Bus decode
   logic             addr_phase;
   logic [5:0]       addr_idx;
   logic [5:0]       wr_idx;
   logic             rd_mem_hit;
   logic             wr_mem_hit;
   logic [5:0]       rd_mem_sel;
   logic [5:0]       wr_mem_sel;
   logic [7:0]       ctrl_rd;
   logic [7:0]       status_rd;
   logic [1:0]       slot;
   logic [31:0]      rdata_d;
   logic             wr_ctrl;
   logic             wr_low;
   logic             wr_mid;
   logic             wr_high;

   function automatic logic in_mem(input logic [5:0] idx);
      return (idx >= LSD_MEM_BASE_IDX) && (idx < LSD_MEM_END_IDX);
   endfunction

   // Only single whole-word transfers are expected; hsize is not checked
   assign addr_phase = hsel_in & htrans_in[1] & hready_in;
   assign addr_idx   = haddr_in[7:2];
   assign wr_idx     = dph_q.addr[7:2];
   assign rd_mem_hit = in_mem(addr_idx);
   assign wr_mem_hit = in_mem(wr_idx);
   assign rd_mem_sel = addr_idx - LSD_MEM_BASE_IDX;
   assign wr_mem_sel = wr_idx - LSD_MEM_BASE_IDX;

   assign wr_ctrl = wr_pend_q & (dph_q.addr == LSD_OFF_CTRL);
   assign wr_low  = wr_pend_q & (dph_q.addr == LSD_OFF_SEG_LOW);
   assign wr_mid  = wr_pend_q & (dph_q.addr == LSD_OFF_SEG_MID);
   assign wr_high = wr_pend_q & (dph_q.addr == LSD_OFF_SEG_HIGH);

   assign ctrl_rd = {ctrl_q.wave_type, 1'b0, ctrl_q.bias_src, 3'b000, ctrl_q.enable};
   assign status_rd = {5'b00000, slot, active_q};

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_mem_hit) begin
         rdata_d[NCOM-1:0] = mem_q[rd_mem_sel];
      end else begin
         case (haddr_in[7:0])
            LSD_OFF_CTRL:     rdata_d[7:0] = ctrl_rd;
            LSD_OFF_SEG_LOW:  rdata_d[7:0] = seg_low_q;
            LSD_OFF_SEG_MID:  rdata_d[7:0] = seg_mid_q;
            LSD_OFF_SEG_HIGH: rdata_d[7:0] = seg_high_q;
            LSD_OFF_STATUS:   rdata_d[7:0] = status_rd;
            default:          rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Bus phase registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dph_q       <= '0;
         wr_pend_q   <= 1'b0;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else if (clk_en_in) begin
         hreadyout_q <= 1'b1;
         wr_pend_q   <= addr_phase & hwrite_in;
         if (addr_phase) dph_q <= '{write: hwrite_in, addr: haddr_in[7:0]};
         if (addr_phase & ~hwrite_in) hrdata_q <= rdata_d;
      end
   end

   assign hreadyout_out = hreadyout_q;
   assign hresp_out     = hresp_q;
   assign hrdata_out    = hrdata_q;

   // ==========================================================
   // Control and enable registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q     <= '0;
         seg_low_q  <= LSD_SEG_RESET;
         seg_mid_q  <= LSD_SEG_RESET;
         seg_high_q <= LSD_SEG_RESET;
      end else if (clk_en_in) begin
         if (wr_ctrl) begin
            ctrl_q.wave_type <= hwdata_in[LSD_CTRL_TYPE_BIT];
            ctrl_q.bias_src  <= hwdata_in[LSD_CTRL_SRC_HI:LSD_CTRL_SRC_LO];
            ctrl_q.enable    <= hwdata_in[LSD_CTRL_EN_BIT];
         end
         if (wr_low) seg_low_q <= hwdata_in[7:0];
         if (wr_mid) seg_mid_q <= hwdata_in[7:0];
         if (wr_high) seg_high_q <= hwdata_in[7:0];
      end
   end

   // ==========================================================
   // Display memory
   // Not reset: contents are undefined until software fills them
   always_ff @(posedge clk_in) begin
      if (clk_en_in & wr_pend_q & wr_mem_hit) mem_q[wr_mem_sel] <= hwdata_in[NCOM-1:0];
   end

   // ==========================================================
   // Frame timing
   logic       src_rise;
   logic       neg;
   logic       run_d;

   assign run_d = ctrl_q.enable & ~sleep_in;

   lsd_pin_sync u_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .clk_en_in (clk_en_in),
      .pin_in    (low_speed_subsystem_clock_in),
      .rise_out  (src_rise)
   );

   lsd_frame_seq u_seq (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .clk_en_in    (clk_en_in),
      .src_rise_in  (src_rise),
      .run_in       (run_d),
      .wave_type_in (ctrl_q.wave_type),
      .slot_out     (slot),
      .neg_out      (neg)
   );

   // ==========================================================
   // Waveform levels
   logic [NSEG-1:0]   seg_en_d;
   logic [2*NCOM-1:0] com_level_d;
   logic [2*NSEG-1:0] seg_level_d;

   // cleared enable leaves pin to general I/O
   // Segments above 23 have no enable bit and always drive
   assign seg_en_d = {{(NSEG-24){1'b1}}, seg_high_q, seg_mid_q, seg_low_q};

   always_comb begin
      com_level_d = '0;
      seg_level_d = '0;
      for (int c = 0; c < NCOM; c++) begin
         com_level_d[2*c +: 2] = run_d ? lsd_com_level(slot == c[1:0], neg) : LSD_LVL_VSS;
      end
      for (int s = 0; s < NSEG; s++) begin
         if (run_d && seg_en_d[s])
            seg_level_d[2*s +: 2] = lsd_seg_level(mem_q[s][slot], neg);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         com_level_q <= '0;
         seg_level_q <= '0;
         seg_en_q    <= '0;
         bias_ext_q  <= 1'b0;
         bias_int_q  <= 3'b000;
         active_q    <= 1'b0;
      end else if (clk_en_in) begin
         com_level_q <= com_level_d;
         seg_level_q <= seg_level_d;
         seg_en_q    <= seg_en_d;
         active_q    <= run_d;
         bias_ext_q  <= (ctrl_q.bias_src == LSD_SRC_EXT);
         bias_int_q  <= {ctrl_q.bias_src == LSD_SRC_MAIN,
                         ctrl_q.bias_src == LSD_SRC_REG3V,
                         ctrl_q.bias_src == LSD_SRC_REF};
      end
   end

   assign com_level_out           = com_level_q;
   assign seg_level_out           = seg_level_q;
   assign seg_drive_enable_out    = seg_en_q;
   assign bias_supply_pin_sel_out = bias_ext_q;
   assign bias_internal_sel_out   = bias_int_q;
   assign display_active_out      = active_q;

   // ==========================================================
   // Checks
   function automatic int extreme_cnt(input logic [2*NCOM-1:0] v);
      int n;
      n = 0;
      for (int c = 0; c < NCOM; c++)
         if (v[2*c +: 2] == LSD_LVL_VA || v[2*c +: 2] == LSD_LVL_VSS) n++;
      return n;
   endfunction

   chk_mid_enable_map: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && wr_mid) |-> ##2 seg_drive_enable_out[15:8] == $past(hwdata_in[7:0], 2))
      else $error("mid enable write not reflected on segments 8..15");

   chk_high_enable_map: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && wr_high) |-> ##2 seg_drive_enable_out[23:16] == $past(hwdata_in[7:0], 2))
      else $error("high enable write not reflected on segments 16..23");

   chk_sleep_forces_off: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && sleep_in) |=> !display_active_out)
      else $error("display active during sleep");

   chk_off_ground: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !display_active_out |-> (com_level_out == '0 && seg_level_out == '0))
      else $error("outputs not grounded while off");

   chk_one_com_select: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      display_active_out |-> extreme_cnt(com_level_out) == 1)
      else $error("not exactly one common line selected");

   chk_bias_external: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (resetn_in && clk_en_in && ctrl_q.bias_src == LSD_SRC_EXT) |=>
         (bias_supply_pin_sel_out && bias_internal_sel_out == 3'b000))
      else $error("code 00 did not select external bias");

   chk_bias_internal: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && ctrl_q.bias_src != LSD_SRC_EXT) |=>
         (!bias_supply_pin_sel_out && $onehot(bias_internal_sel_out)))
      else $error("internal bias code not one-hot");

   chk_disabled_pin_idle: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && !seg_en_d[8]) |=> (!seg_drive_enable_out[8] && seg_level_out[17:16] == 2'h0))
      else $error("disabled segment pin still driven");

   // Counts general I/O pins that still carry a drive level
   function automatic int gpio_driven(input logic [NSEG-1:0] en, input logic [2*NSEG-1:0] lvl);
      int n;
      n = 0;
      for (int s = 0; s < NSEG; s++)
         if (!en[s] && lvl[2*s +: 2] != LSD_LVL_VSS) n++;
      return n;
   endfunction

   chk_gpio_pins_quiet: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      gpio_driven(seg_drive_enable_out, seg_level_out) == 0)
      else $error("general I/O pin carries a drive level");

   chk_com_polarity_match: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      display_active_out |-> (com_level_out[0] == com_level_out[2]
         && com_level_out[2] == com_level_out[4] && com_level_out[4] == com_level_out[6]))
      else $error("common lines disagree on polarity");

   chk_com_phase_follows: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      display_active_out |-> com_level_out[0] != $past(neg))
      else $error("common levels do not follow frame polarity");

   chk_active_follows_enable: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (clk_en_in && ctrl_q.enable && !sleep_in) |=> display_active_out)
      else $error("display not active while enabled and awake");

endmodule // lsd_driver
`default_nettype wire

// >>> lsd_panel_model.sv
// Glass panel model: integrates pixel voltage once per drive state
`timescale 1ns/1ps
`default_nettype none
module lsd_panel_model #(
   parameter int SEG = 24
) (
   input  wire logic        clk_in,
   input  wire logic        clear_in,
   input  wire logic        active_in,
   input  wire logic [7:0]  com_level_in,
   input  wire logic [71:0] seg_level_in,
   output int               sample_count_out,
   output int               dc_on_out,
   output int               dc_off_out,
   output int               rms_on_out,
   output int               rms_off_out,
   output int               com0_changes_out,
   output int               shape_bad_out
);
   // ==========================================================
   // Pixel voltages: com0 pixel is lit, com1 pixel is dark
   logic [7:0] prev_q;
   int         v_on;
   int         v_off;
   int         extremes;

   always_comb begin
      v_on     = int'(com_level_in[1:0]) - int'(seg_level_in[2*SEG+:2]);
      v_off    = int'(com_level_in[3:2]) - int'(seg_level_in[2*SEG+:2]);
      extremes = 0;
      for (int c = 0; c < 4; c++) begin
         extremes += (com_level_in[2*c+:2] inside {2'h0, 2'h3}) ? 1 : 0;
      end
   end

   // ==========================================================
   // One sample per drive state, so weighting is per tick, not per cycle
   always @(posedge clk_in) begin
      if (clear_in) begin
         sample_count_out <= 0;
         dc_on_out        <= 0;
         dc_off_out       <= 0;
         rms_on_out       <= 0;
         rms_off_out      <= 0;
         com0_changes_out <= 0;
         shape_bad_out    <= 0;
      end else if (active_in && com_level_in !== prev_q) begin
         sample_count_out <= sample_count_out + 1;
         dc_on_out   <= dc_on_out + v_on;
         dc_off_out  <= dc_off_out + v_off;
         rms_on_out  <= rms_on_out + v_on * v_on;
         rms_off_out <= rms_off_out + v_off * v_off;
         if (com_level_in[1:0] !== prev_q[1:0]) begin
            com0_changes_out <= com0_changes_out + 1;
         end
         if (extremes != 1) begin
            shape_bad_out <= shape_bad_out + 1;
         end
      end
      prev_q <= com_level_in;
   end
endmodule // lsd_panel_model
`default_nettype wire

// >>> lsd_driver_tb.sv
// Self-checking bench for the segment/common display driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module lsd_driver_tb;
   import lsd_pkg::*;
   // ==========================================================
   // Stimulus and observation
   logic        clk_in    = 1'b0;
   logic        resetn_in = 1'b0;
   logic        sleep     = 1'b0;
   logic        clk_en    = 1'b1;
   logic        ls_clk    = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = 32'h0;
   logic        clear     = 1'b1;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  com_lvl;
   logic [71:0] seg_lvl;
   logic [35:0] seg_en;
   logic        pin_sel;
   logic [2:0]  int_sel;
   logic        active;
   logic [31:0] rd;
   int          p_count, p_dc_on, p_dc_off, p_rms_on, p_rms_off, p_changes, p_shape;
   int          bad_count = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          ls_edges = 0;
   int          ls_mark = 0;
   int          ls_delta = 0;
   int          a_changes;
   int          b_changes;

   always #12.5 clk_in = ~clk_in;
   // Low-speed clock locked to a fixed phase so tick spacing is exact
   always #125 ls_clk = ~ls_clk;
   always @(posedge ls_clk) ls_edges++;
   always @(p_count) begin
      ls_delta = ls_edges - ls_mark;
      ls_mark  = ls_edges;
   end

   lsd_driver uut (
      .clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en), .sleep_in(sleep),
      .low_speed_subsystem_clock_in(ls_clk), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp),
      .hrdata_out(hrdata), .com_level_out(com_lvl), .seg_level_out(seg_lvl),
      .seg_drive_enable_out(seg_en), .bias_supply_pin_sel_out(pin_sel),
      .bias_internal_sel_out(int_sel), .display_active_out(active));

   lsd_panel_model #(.SEG(24)) panel (
      .clk_in(clk_in), .clear_in(clear), .active_in(active), .com_level_in(com_lvl),
      .seg_level_in(seg_lvl), .sample_count_out(p_count), .dc_on_out(p_dc_on),
      .dc_off_out(p_dc_off), .rms_on_out(p_rms_on), .rms_off_out(p_rms_off),
      .com0_changes_out(p_changes), .shape_bad_out(p_shape));

   // ==========================================================
   // Closing report and hang guard
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         test_done();
      end
   end

   // ==========================================================
   // AHB-Lite single transfer: hold each phase until hready is seen
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdata);
      @(posedge clk_in);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      @(posedge clk_in);
      while (hreadyout !== 1'b1) @(posedge clk_in);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      @(posedge clk_in);
      while (hreadyout !== 1'b1) @(posedge clk_in);
      rdata = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rd);
      `CHK(nm, exp, rd)
      `CHK("okay resp", 1'b0, hresp)
   endtask

   // Sixteen drive states of either waveform type (two type A frames, four type B frames), then switch off
   task automatic run_frames(input logic typ, output int changes);
      int n;
      n = 0;
      clear <= 1'b1;
      @(posedge clk_in);
      clear <= 1'b0;
      wr(LSD_OFF_CTRL, {24'h0, typ, 6'h00, 1'b1});
      while (p_count < 16 && n < 4000) begin
         @(posedge clk_in);
         n++;
      end
      @(posedge clk_in);
      `CHK("frame samples", 16, p_count)
      `CHK("dc lit pixel", 0, p_dc_on)
      `CHK("dc dark pixel", 0, p_dc_off)
      `CHK("lit above dark", 1'b1, p_rms_on > p_rms_off)
      `CHK("com shape", 0, p_shape)
      `CHK("tick spacing", 8, ls_delta)
      `CHK("gpio seg level", 2'h0, seg_lvl[19:18])
      ahb(1'b0, LSD_OFF_STATUS, 32'h0, rd);
      `CHK("status active", 1'b1, rd[0])
      changes = p_changes;
      wr(LSD_OFF_CTRL, 32'h0);
      repeat (3) @(posedge clk_in);
      `CHK("off com", 8'h00, com_lvl)
      `CHK("off seg", 72'h0, seg_lvl)
      `CHK("off active", 1'b0, active)
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      `CHK("seg lines", 72, $bits(uut.seg_level_out))
      `CHK("com lines", 8, $bits(uut.com_level_out))
      rd_chk("mid reset", LSD_OFF_SEG_MID, 32'h0);
      rd_chk("high reset", LSD_OFF_SEG_HIGH, 32'h0);
      `CHK("pins reset", 16'h0, seg_en[23:8])
      wr(LSD_OFF_SEG_MID, 32'hA5);
      wr(LSD_OFF_SEG_HIGH, 32'h3C);
      rd_chk("mid back", LSD_OFF_SEG_MID, 32'hA5);
      rd_chk("high back", LSD_OFF_SEG_HIGH, 32'h3C);
      `CHK("mid pins", 8'hA5, seg_en[15:8])
      `CHK("high pins", 8'h3C, seg_en[23:16])
      rd_chk("unmapped", 8'hE0, 32'h0);
      for (int code = 0; code < 4; code++) begin
         wr(LSD_OFF_CTRL, {26'h0, code[1:0], 4'h0});
         repeat (3) @(posedge clk_in);
         `CHK("pin source", code == 0, pin_sel)
         `CHK("internal source", (code == 0) ? 3'h0 : 3'h1 << (code - 1), int_sel)
      end
      wr(LSD_OFF_CTRL, 32'h0);
      wr(8'hA0, 32'h5);
      rd_chk("memory back", 8'hA0, 32'h5);
      run_frames(1'b0, a_changes);
      run_frames(1'b1, b_changes);
      `CHK("type b slower", 1'b1, b_changes < a_changes)
      wr(LSD_OFF_CTRL, 32'h1);
      repeat (3) @(posedge clk_in);
      sleep <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("sleep active", 1'b0, active)
      `CHK("sleep com", 8'h00, com_lvl)
      sleep <= 1'b0;
      repeat (3) @(posedge clk_in);
      `CHK("wake active", 1'b1, active)
      clk_en <= 1'b0;
      sleep  <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("frozen active", 1'b1, active)
      clk_en <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("thawed sleep", 1'b0, active)
      test_done();
   end
endmodule // lsd_driver_tb
`default_nettype wire
